// ==== rtl/fpm_top.sv ====
// Front-panel menu controller with APB status and remote settings access.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "fpm_map.svh"

module fpm_top
#(
  parameter logic [32:0] TIMEOUT_CYC =
    33'(64'(`FPM_TIMEOUT_S) * 64'(`FPM_NS_PER_S) / 64'(`FPM_CLK_PERIOD_NS)),
  parameter logic [32:0] PU_STEP_CYC =
    33'(64'(`FPM_PU_STEP_MS) * 64'(`FPM_NS_PER_MS) / 64'(`FPM_CLK_PERIOD_NS))
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front-panel switches, debounced levels
  input wire fpm_pkg::fpm_sw_s sw,
  // Plant status
  input wire logic [1:0] pll_unlock,
  input wire logic ext_ref_ok,
  // Retained storage
  input wire fpm_pkg::fpm_cfg_s nv_rd_data,
  output logic nv_wr_en,
  output fpm_pkg::fpm_cfg_s nv_wr_data,
  // Display
  output fpm_pkg::fpm_state_e disp_state,
  output logic [1:0] disp_cursor,
  output logic disp_yes,
  output fpm_pkg::fpm_legend_e ref_legend,
  // Plant controls and LEDs
  output logic [8:0] gain_out,
  output logic rf_mute,
  output logic ref_sel_ext,
  output logic alarm_led,
  output logic remote_led
);

  fpm_pkg::fpm_core_s s_reg;
  fpm_pkg::fpm_core_s s_next;
  fpm_pkg::fpm_cfg_s committed;
  fpm_pkg::fpm_cfg_s commit_cfg;
  fpm_pkg::fpm_cfg_s cfg_src;
  fpm_pkg::fpm_sw_s act;
  fpm_pkg::fpm_status_s status;
  logic act_any;
  logic in_session;
  logic nv_load;
  logic commit;
  logic [1:0] cur_r;
  logic [8:0] gstep;
  logic [12:0] ostep;
  logic [12:0] ofs_w;
  logic [12:0] ofs_sum;

  // --------------------------------------------------------------------------
  // Retained settings
  // --------------------------------------------------------------------------
  fpm_nvstore u_nv
  (
    .pclk(pclk),
    .presetn(presetn),
    .load(nv_load),
    .nv_rd_data(nv_rd_data),
    .commit(commit),
    .commit_cfg(commit_cfg),
    .committed(committed),
    .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data)
  );

  // --------------------------------------------------------------------------
  // Switch actuation and cursor helpers
  // --------------------------------------------------------------------------
  assign act = fpm_pkg::fpm_sw_s'(sw & ~s_reg.sw_prev);
  assign act_any = |act;
  assign in_session = (s_reg.st != fpm_pkg::ST_PU_DARK) && (s_reg.st != fpm_pkg::ST_PU_MODEL) &&
                      (s_reg.st != fpm_pkg::ST_PU_FREQ) && (s_reg.st != fpm_pkg::ST_NORMAL);
  // Gain and offset carry three digit places before the return marker; other items one.
  assign cur_r = ((s_reg.st == fpm_pkg::ST_GAIN) || (s_reg.st == fpm_pkg::ST_REFO)) ?
                 `FPM_CUR_WIDE : `FPM_CUR_NARROW;
  assign gstep = (s_reg.cur == 2'h0) ? `FPM_GAIN_STEP0 :
                 (s_reg.cur == 2'h1) ? `FPM_GAIN_STEP1 : `FPM_GAIN_STEP2;
  assign ostep = (s_reg.cur == 2'h0) ? `FPM_OFS_STEP0 :
                 (s_reg.cur == 2'h1) ? `FPM_OFS_STEP1 : `FPM_OFS_STEP2;
  assign ofs_w = {s_reg.work.offset[11], s_reg.work.offset};
  assign ofs_sum = act.up ? 13'(ofs_w + ostep) : 13'(ofs_w - ostep);
  assign nv_load = (s_reg.st == fpm_pkg::ST_PU_DARK) && (s_reg.tmr == 33'h0);

  // --------------------------------------------------------------------------
  // Commit sources
  // --------------------------------------------------------------------------
  // A panel commit wins over a remote write in the same cycle.
  always_comb
  begin
    commit = 1'b0;
    commit_cfg = s_reg.work;
    if ((s_reg.st == fpm_pkg::ST_SAVE) && act.sel && s_reg.yes)
    begin
      commit = 1'b1;
    end
    else if (psel && penable && s_reg.pready && pwrite && (paddr == `FPM_ADDR_CFG) && committed.remote)
    begin
      commit = 1'b1;
      commit_cfg = fpm_pkg::fpm_cfg_s'(pwdata[30:0]);
    end
  end

  assign cfg_src = commit ? commit_cfg : committed;

  always_comb
  begin
    status = '0;
    status.st = s_reg.st;
    status.legend = s_reg.legend;
    status.alarm = s_reg.alarm;
    status.ref_ext = s_reg.ref_ext;
    status.in_session = in_session;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.sw_prev = sw;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    case (s_reg.st)
      fpm_pkg::ST_PU_DARK, fpm_pkg::ST_PU_MODEL, fpm_pkg::ST_PU_FREQ:
      begin
        if (s_reg.tmr == 33'(PU_STEP_CYC - 33'h1))
        begin
          s_next.tmr = '0;
          s_next.st = fpm_pkg::fpm_state_e'(s_reg.st << 1);
          s_next.work = committed;
        end
        else
        begin
          s_next.tmr = 33'(s_reg.tmr + 33'h1);
        end
      end
      fpm_pkg::ST_NORMAL:
      begin
        s_next.tmr = '0;
        s_next.work = committed;
        if (act.sel)
        begin
          s_next.st = fpm_pkg::ST_GAIN;
          s_next.cur = 2'h0;
        end
      end
      default:
      begin
        if (act_any)
        begin
          s_next.tmr = '0;
        end
        else if (s_reg.tmr == 33'(TIMEOUT_CYC - 33'h1))
        begin
          s_next.tmr = '0;
          s_next.st = fpm_pkg::ST_NORMAL;
          s_next.work = committed;
        end
        else
        begin
          s_next.tmr = 33'(s_reg.tmr + 33'h1);
        end
        if (act.left && (s_reg.cur != 2'h0))
        begin
          s_next.cur = 2'(s_reg.cur - 2'h1);
        end
        else if (act.right && (s_reg.cur != cur_r))
        begin
          s_next.cur = 2'(s_reg.cur + 2'h1);
        end
        if (act.sel)
        begin
          if (s_reg.st == fpm_pkg::ST_SAVE)
          begin
            s_next.st = fpm_pkg::ST_NORMAL;
            s_next.work = s_reg.yes ? s_reg.work : committed;
          end
          else if ((s_reg.cur == cur_r) || (s_reg.st == fpm_pkg::ST_ADDR))
          begin
            s_next.st = fpm_pkg::ST_SAVE;
            s_next.yes = 1'b1;
            s_next.cur = 2'h0;
          end
          else
          begin
            s_next.st = fpm_pkg::fpm_state_e'(s_reg.st << 1);
            s_next.cur = 2'h0;
          end
        end
        else if ((act.up || act.down) && ((s_reg.cur != cur_r) || (s_reg.st == fpm_pkg::ST_SAVE)))
        begin
          case (s_reg.st)
            fpm_pkg::ST_GAIN:
            begin
              if (act.up)
              begin
                s_next.work.gain = (s_reg.work.gain > 9'(`FPM_GAIN_MAX - gstep)) ?
                                   `FPM_GAIN_MAX : 9'(s_reg.work.gain + gstep);
              end
              else
              begin
                s_next.work.gain = (s_reg.work.gain < gstep) ? 9'h000 : 9'(s_reg.work.gain - gstep);
              end
            end
            fpm_pkg::ST_MUTE:
            begin
              s_next.work.mute = ~s_reg.work.mute;
            end
            fpm_pkg::ST_REMOTE:
            begin
              s_next.work.remote = ~s_reg.work.remote;
            end
            fpm_pkg::ST_RIF:
            begin
              s_next.work.rif = ~s_reg.work.rif;
            end
            fpm_pkg::ST_REFM:
            begin
              if (act.up)
              begin
                s_next.work.refm = (s_reg.work.refm == `FPM_REF_AUTO) ? `FPM_REF_INT :
                                   2'(s_reg.work.refm + 2'h1);
              end
              else
              begin
                s_next.work.refm = (s_reg.work.refm == `FPM_REF_INT) ? `FPM_REF_AUTO :
                                   2'(s_reg.work.refm - 2'h1);
              end
            end
            fpm_pkg::ST_REFO:
            begin
              if (act.up && ($signed(ofs_sum) > $signed(`FPM_OFS_MAX)))
              begin
                s_next.work.offset = 12'(`FPM_OFS_MAX);
              end
              else if (act.down && ($signed(ofs_sum) < $signed(`FPM_OFS_MIN)))
              begin
                s_next.work.offset = 12'(`FPM_OFS_MIN);
              end
              else
              begin
                s_next.work.offset = ofs_sum[11:0];
              end
            end
            fpm_pkg::ST_ADDR:
            begin
              s_next.work.addr = act.up ? 5'(s_reg.work.addr + 5'h01) : 5'(s_reg.work.addr - 5'h01);
            end
            default:
            begin
              s_next.yes = ~s_reg.yes;
            end
          endcase
        end
      end
    endcase

    // Gain follows the edit live; every other setting waits for the commit.
    s_next.gain_out = (commit || ((s_next.st != fpm_pkg::ST_NORMAL) && in_session)) ?
                      s_next.work.gain : committed.gain;
    s_next.mute_out = cfg_src.mute;
    s_next.remote_led = cfg_src.remote;
    s_next.alarm = |pll_unlock;
    if (cfg_src.refm == `FPM_REF_INT)
    begin
      s_next.ref_ext = 1'b0;
      s_next.legend = fpm_pkg::LEG_INT;
    end
    else if (cfg_src.refm == `FPM_REF_EXT)
    begin
      s_next.ref_ext = 1'b1;
      s_next.legend = fpm_pkg::LEG_EXT;
    end
    else if (ext_ref_ok)
    begin
      s_next.ref_ext = 1'b1;
      s_next.legend = fpm_pkg::LEG_AUTO_E;
    end
    else
    begin
      s_next.ref_ext = 1'b0;
      s_next.legend = fpm_pkg::LEG_AUTO_I;
    end

    // APB: data is captured in the setup cycle so the access phase completes at once.
    if (psel && !penable)
    begin
      s_next.pready = 1'b1;
      if (paddr == `FPM_ADDR_STATUS)
      begin
        s_next.prdata = pwrite ? s_reg.prdata : 32'(status);
      end
      else if (paddr == `FPM_ADDR_CFG)
      begin
        s_next.prdata = pwrite ? s_reg.prdata : {1'b0, committed};
      end
      else
      begin
        s_next.prdata = 32'h0000_0000;
        s_next.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.st <= fpm_pkg::ST_PU_DARK;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign disp_state = s_reg.st;
  assign disp_cursor = s_reg.cur;
  assign disp_yes = s_reg.yes;
  assign ref_legend = s_reg.legend;
  assign gain_out = s_reg.gain_out;
  assign rf_mute = s_reg.mute_out;
  assign ref_sel_ext = s_reg.ref_ext;
  assign alarm_led = s_reg.alarm;
  assign remote_led = s_reg.remote_led;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_dark_done;
    (s_reg.st == fpm_pkg::ST_PU_DARK) ##1 (s_reg.st != fpm_pkg::ST_PU_DARK);
  endsequence

  sequence s_model_done;
    (s_reg.st == fpm_pkg::ST_PU_MODEL) ##1 (s_reg.st != fpm_pkg::ST_PU_MODEL);
  endsequence

  property p_commit_cause;
    @(posedge pclk) disable iff (!presetn)
    (commit && !pwrite) |-> ((s_reg.st == fpm_pkg::ST_SAVE) && s_reg.yes && act.sel);
  endproperty
  a_commit_cause: assert property (p_commit_cause) else $error("Commit without confirmed save.");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    (in_session && !act_any && (s_reg.tmr == 33'(TIMEOUT_CYC - 33'h1))) |=>
    ((s_reg.st == fpm_pkg::ST_NORMAL) && (s_reg.work == $past(committed)));
  endproperty
  a_timeout: assert property (p_timeout) else $error("Idle session not abandoned.");

  property p_return;
    @(posedge pclk) disable iff (!presetn)
    (in_session && (s_reg.st != fpm_pkg::ST_SAVE) && act.sel && (s_reg.cur == cur_r)) |=>
    (s_reg.st == fpm_pkg::ST_SAVE) && s_reg.yes;
  endproperty
  a_return: assert property (p_return) else $error("Return marker did not open save prompt.");

  property p_pu_order;
    @(posedge pclk) disable iff (!presetn)
    s_dark_done |-> (s_reg.st == fpm_pkg::ST_PU_MODEL) ##0 (s_model_done or
    (s_reg.st == fpm_pkg::ST_PU_MODEL));
  endproperty
  a_pu_order: assert property (p_pu_order) else $error("Power-up display order broken.");

  property p_cursor_right;
    @(posedge pclk) disable iff (!presetn)
    (in_session && act.right && !act.left && (s_reg.cur != cur_r) && !act.sel) |=>
    (s_reg.cur == 2'($past(s_reg.cur) + 2'h1));
  endproperty
  a_cursor_right: assert property (p_cursor_right) else $error("Cursor did not step right.");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    ((s_reg.st == fpm_pkg::ST_MUTE) && (s_reg.cur == 2'h0) && act.down && !act.sel) |=>
    (s_reg.work.mute != $past(s_reg.work.mute));
  endproperty
  a_toggle: assert property (p_toggle) else $error("On/off item did not toggle.");

  property p_alarm;
    @(posedge pclk) disable iff (!presetn)
    (|pll_unlock) |=> alarm_led;
  endproperty
  a_alarm: assert property (p_alarm) else $error("Lock loss without alarm.");

  property p_auto_int;
    @(posedge pclk) disable iff (!presetn)
    ((cfg_src.refm == `FPM_REF_AUTO) && !ext_ref_ok) |=>
    ((ref_legend == fpm_pkg::LEG_AUTO_I) && !ref_sel_ext);
  endproperty
  a_auto_int: assert property (p_auto_int) else $error("Auto mode did not fall back to internal.");

  property p_save_no;
    @(posedge pclk) disable iff (!presetn)
    ((s_reg.st == fpm_pkg::ST_SAVE) && act.sel && !s_reg.yes && !pwrite) |->
    !commit ##1 ((s_reg.st == fpm_pkg::ST_NORMAL) && (gain_out == committed.gain));
  endproperty
  a_save_no: assert property (p_save_no) else $error("No answer did not restore settings.");

  property p_gain_range;
    @(posedge pclk) disable iff (!presetn)
    (s_reg.st == fpm_pkg::ST_GAIN) |-> (s_reg.work.gain <= `FPM_GAIN_MAX) || $past(s_reg.st != fpm_pkg::ST_GAIN);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("Gain edit out of range.");

endmodule // fpm_top

// ==== rtl/fpm_map.svh ====
// Address map, field limits and timing figures of the front-panel menu controller.
//
// Overview of operation
// - Settings change only for a session opened and closed by select with a yes, or by a remote write in remote mode.
// - About 30 s without switch activity abandons the session and restores settings.
// - Choosing the return marker, or passing the last item, opens the save prompt.
// - Committed settings are kept in retained storage and reloaded at power-up.
// - Power-up shows dark segments, then model and version, then frequency and gain.
// - Each horizontal actuation moves the cursor one place left or right, but not left of the first place or right of the return marker.
// - While editing gain, vertical raises or lowers the digit under the cursor.
// - Vertical toggles on/off items whichever direction is pressed.
// - Gain edits drive the output at once; storage is written only on yes or by a remote write.
// - Gain steps are 0.5, 1 or 10 dB by cursor position.
// - Select on a shown value advances to the next menu item.
// - Yes at the save prompt commits all settings; no restores the previous ones.
// - Alarm is lit whenever any oscillator loop reports loss of lock.
// - Remote LED is lit whenever remote mode is selected.
// - Internal mode uses and routes the built-in oscillator with an internal legend.
// - External mode uses and routes the external input with an external legend.
// - Auto mode uses the external input while its level is good, legend auto-E.
// - Auto mode falls back to the internal oscillator on low level, legend auto-I.
// - Panel edits hold gain from 000 to 300 in tenths of a dB; remote writes are not clamped.
// - Reference mode codes are 0 internal, 1 external, 2 auto.
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FPM_ADDR_STATUS 12'h000
`define FPM_ADDR_CFG 12'h004

// ----------------------------------------------------------------------------
// Setting limits and steps
// ----------------------------------------------------------------------------
`define FPM_GAIN_MAX 9'h12c
`define FPM_GAIN_STEP0 9'h005
`define FPM_GAIN_STEP1 9'h00a
`define FPM_GAIN_STEP2 9'h064
`define FPM_OFS_MAX 13'h07d0
`define FPM_OFS_MIN 13'h1830
`define FPM_OFS_STEP0 13'h0001
`define FPM_OFS_STEP1 13'h000a
`define FPM_OFS_STEP2 13'h0064
`define FPM_REF_INT 2'h0
`define FPM_REF_EXT 2'h1
`define FPM_REF_AUTO 2'h2
`define FPM_CUR_WIDE 2'h3
`define FPM_CUR_NARROW 2'h1
`define FPM_CFG_RESET 31'h0000_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FPM_CLK_PERIOD_NS 4
`define FPM_NS_PER_S 1000000000
`define FPM_NS_PER_MS 1000000
`define FPM_TIMEOUT_S 30
`define FPM_PU_STEP_MS 1000

`endif

// ==== rtl/fpm_pkg.sv ====
// Types shared by the front-panel menu controller.
package fpm_pkg;

  typedef enum logic [11:0] {
    ST_PU_DARK = 12'h001,
    ST_PU_MODEL = 12'h002,
    ST_PU_FREQ = 12'h004,
    ST_NORMAL = 12'h008,
    ST_GAIN = 12'h010,
    ST_MUTE = 12'h020,
    ST_REFM = 12'h040,
    ST_REFO = 12'h080,
    ST_REMOTE = 12'h100,
    ST_RIF = 12'h200,
    ST_ADDR = 12'h400,
    ST_SAVE = 12'h800
  } fpm_state_e;

  typedef enum logic [1:0] {
    LEG_INT = 2'h0,
    LEG_EXT = 2'h1,
    LEG_AUTO_E = 2'h2,
    LEG_AUTO_I = 2'h3
  } fpm_legend_e;

  typedef struct packed {
    logic [11:0] offset;
    logic [4:0] addr;
    logic rif;
    logic remote;
    logic [1:0] refm;
    logic mute;
    logic [8:0] gain;
  } fpm_cfg_s;

  typedef struct packed {
    logic sel;
    logic left;
    logic right;
    logic up;
    logic down;
  } fpm_sw_s;

  typedef struct packed {
    logic [14:0] zero;
    logic in_session;
    logic ref_ext;
    logic alarm;
    fpm_legend_e legend;
    fpm_state_e st;
  } fpm_status_s;

  typedef struct packed {
    fpm_state_e st;
    logic [32:0] tmr;
    logic [1:0] cur;
    logic yes;
    fpm_cfg_s work;
    fpm_sw_s sw_prev;
    logic [8:0] gain_out;
    logic mute_out;
    fpm_legend_e legend;
    logic ref_ext;
    logic alarm;
    logic remote_led;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fpm_core_s;

  typedef struct packed {
    fpm_cfg_s committed;
    logic wr_en;
    fpm_cfg_s wr_data;
  } fpm_nv_s;

endpackage

// ==== rtl/fpm_nvstore.sv ====
// Committed-settings holder that mirrors the retained storage.
`timescale 1ns/1ps
`include "fpm_map.svh"

module fpm_nvstore
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load from and commit to retained storage
  input wire logic load,
  input wire fpm_pkg::fpm_cfg_s nv_rd_data,
  input wire logic commit,
  input wire fpm_pkg::fpm_cfg_s commit_cfg,
  // Results
  output fpm_pkg::fpm_cfg_s committed,
  output logic nv_wr_en,
  output fpm_pkg::fpm_cfg_s nv_wr_data
);

  fpm_pkg::fpm_nv_s s_reg;
  fpm_pkg::fpm_nv_s s_next;

  // The stored image is taken after reset release, never under the reset itself.
  always_comb
  begin
    s_next = s_reg;
    s_next.wr_en = 1'b0;
    if (load)
    begin
      s_next.committed = nv_rd_data;
    end
    else if (commit)
    begin
      s_next.committed = commit_cfg;
      s_next.wr_en = 1'b1;
      s_next.wr_data = commit_cfg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign committed = s_reg.committed;
  assign nv_wr_en = s_reg.wr_en;
  assign nv_wr_data = s_reg.wr_data;

endmodule // fpm_nvstore

// ==== dv/fpm_operator.sv ====
// Operator model working the front-panel switches.
`timescale 1ns/1ps

module fpm_operator
(
  // Clock
  input wire logic pclk,
  // Switch levels
  output fpm_pkg::fpm_sw_s sw
);
  initial sw = '0;

  // A press holds for two cycles, then rests long enough for the outputs to settle.
  task automatic press(input int unsigned idx);
    @(posedge pclk);
    sw <= fpm_pkg::fpm_sw_s'(5'h01 << idx);
    repeat (2) @(posedge pclk);
    sw <= '0;
    repeat (3) @(posedge pclk);
  endtask
endmodule // fpm_operator

// ==== dv/testbench.sv ====
// Self-checking bench of the front-panel menu controller.
`timescale 1ns/1ps

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fpm_pkg::fpm_sw_s sw;
  logic [1:0] pll_unlock = 2'h0;
  logic ext_ref_ok = 1'b0;
  fpm_pkg::fpm_cfg_s nv_cfg = {12'h000, 5'h00, 1'b0, 1'b1, 2'h0, 1'b0, 9'h064};
  logic nv_wr_en;
  fpm_pkg::fpm_cfg_s nv_wr_data;
  fpm_pkg::fpm_state_e disp_state;
  logic [1:0] disp_cursor;
  logic disp_yes;
  fpm_pkg::fpm_legend_e ref_legend;
  logic [8:0] gain_out;
  logic rf_mute;
  logic ref_sel_ext;
  logic alarm_led;
  logic remote_led;
  int err_count = 0;
  int cmp_count = 0;
  int wr_seen = 0;
  logic [31:0] rd;
  logic err;

  always #2 pclk = ~pclk;

  fpm_top #(.TIMEOUT_CYC(33'd40), .PU_STEP_CYC(33'd4)) fpm_top_inst
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sw(sw),
    .pll_unlock(pll_unlock),
    .ext_ref_ok(ext_ref_ok),
    .nv_rd_data(nv_cfg),
    .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data),
    .disp_state(disp_state),
    .disp_cursor(disp_cursor),
    .disp_yes(disp_yes),
    .ref_legend(ref_legend),
    .gain_out(gain_out),
    .rf_mute(rf_mute),
    .ref_sel_ext(ref_sel_ext),
    .alarm_led(alarm_led),
    .remote_led(remote_led)
  );

  fpm_operator fpm_operator_inst (.pclk(pclk), .sw(sw));

  // Retained storage keeps whatever the controller writes.
  always @(posedge pclk)
    if (nv_wr_en === 1'b1)
    begin
      nv_cfg <= nv_wr_data;
      wr_seen <= wr_seen + 1;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      err_count++;
      $display("[FAIL] %0t apb no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic reach(input fpm_pkg::fpm_state_e s);
    int n;
    n = 0;
    while (disp_state !== s && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(disp_state), 32'(s), "state");
  endtask

  task automatic t_power;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reach(fpm_pkg::ST_PU_DARK);
    reach(fpm_pkg::ST_PU_MODEL);
    reach(fpm_pkg::ST_PU_FREQ);
    reach(fpm_pkg::ST_NORMAL);
    repeat (2) @(posedge pclk);
    chk(32'(gain_out), 32'(nv_cfg.gain), "gain");
    chk(32'(rf_mute), 32'(nv_cfg.mute), "mute");
    chk(32'(remote_led), 32'h1, "remote");
    chk(32'(ref_sel_ext), 32'h0, "refsel");
  endtask

  task automatic t_edit;
    fpm_operator_inst.press(4);
    reach(fpm_pkg::ST_GAIN);
    fpm_operator_inst.press(1);
    chk(32'(gain_out), 32'd105, "g05");
    fpm_operator_inst.press(2);
    chk(32'(disp_cursor), 32'h1, "cur");
    fpm_operator_inst.press(1);
    chk(32'(gain_out), 32'd115, "g1");
    fpm_operator_inst.press(2);
    fpm_operator_inst.press(1);
    chk(32'(gain_out), 32'd215, "g10");
    fpm_operator_inst.press(3);
    fpm_operator_inst.press(0);
    chk(32'(gain_out), 32'd205, "gdn");
    fpm_operator_inst.press(2);
    fpm_operator_inst.press(2);
    fpm_operator_inst.press(4);
    chk(32'(disp_state), 32'(fpm_pkg::ST_SAVE), "save");
    chk(32'(disp_yes), 32'h1, "yes");
    fpm_operator_inst.press(0);
    fpm_operator_inst.press(4);
    chk(32'(gain_out), 32'd100, "revert");
    chk(32'(wr_seen), 32'h0, "nowr");
  endtask

  task automatic t_idle;
    fpm_operator_inst.press(4);
    repeat (30) @(posedge pclk);
    fpm_operator_inst.press(1);
    repeat (30) @(posedge pclk);
    chk(32'(disp_state), 32'(fpm_pkg::ST_GAIN), "alive");
    repeat (50) @(posedge pclk);
    chk(32'(disp_state), 32'(fpm_pkg::ST_NORMAL), "tmo");
    chk(32'(gain_out), 32'd100, "tmog");
  endtask

  task automatic t_commit;
    fpm_pkg::fpm_state_e seq [6];
    seq = '{fpm_pkg::ST_REFM, fpm_pkg::ST_REFO, fpm_pkg::ST_REMOTE, fpm_pkg::ST_RIF, fpm_pkg::ST_ADDR,
      fpm_pkg::ST_SAVE};
    fpm_operator_inst.press(4);
    fpm_operator_inst.press(1);
    fpm_operator_inst.press(4);
    fpm_operator_inst.press(1);
    fpm_operator_inst.press(0);
    fpm_operator_inst.press(0);
    chk(32'(rf_mute), 32'h0, "mlive");
    foreach (seq[i])
    begin
      fpm_operator_inst.press(4);
      chk(32'(disp_state), 32'(seq[i]), "next");
    end
    fpm_operator_inst.press(4);
    chk(32'(wr_seen), 32'h1, "wr");
    chk(32'(rf_mute), 32'h1, "mset");
    chk(32'(nv_cfg.gain), 32'd105, "nvg");
  endtask

  task automatic t_plant;
    fpm_pkg::fpm_cfg_s c;
    for (int i = 0; i < 4; i++)
    begin
      pll_unlock <= 2'(i);
      repeat (3) @(posedge pclk);
      chk(32'(alarm_led), 32'(i != 0), "alarm");
    end
    pll_unlock <= 2'h0;
    repeat (3) @(posedge pclk);
    chk(32'(alarm_led), 32'h0, "alarm_off");
    c = nv_cfg;
    for (int k = 0; k < 4; k++)
    begin
      c.refm = (k > 1) ? 2'h2 : 2'(k);
      ext_ref_ok <= (k != 3);
      apb(1'b1, 12'h004, {1'b0, c});
      chk(32'(ref_legend), 32'(k), "leg");
      chk(32'(ref_sel_ext), 32'(k == 1 || k == 2), "sel");
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, {16'h0000, 1'(k == 1 || k == 2), 1'b0, 2'(k), 12'h008}, "stat");
    end
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({31'h0, err}, 32'h1, "unmap");
    c.remote = 1'b0;
    apb(1'b1, 12'h004, {1'b0, c});
    chk(32'(remote_led), 32'h0, "rled");
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, {1'b0, c}, "cfgrd");
    chk(32'(nv_cfg), 32'(c), "nvcfg");
  endtask

  task automatic close_out;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #40000;
    err_count++;
    close_out();
  end

  initial
  begin
    t_power();
    t_edit();
    t_idle();
    t_commit();
    t_power();
    t_plant();
    close_out();
  end
endmodule // testbench
